// [core/sdt_out_dma.v]
// Behaviour
// RULE_01 - transparent: all 32 bits out, no coding
// RULE_02 - mode field picks LSB-first or MSB-first
// RULE_03 - one data bit per synthesizer tick
// RULE_04 - transparent words use byte-order bit too
// RULE_05 - byte-order set: MSB from a+3, else a
// RULE_06 - software loads bases, size multiple of 64
// RULE_07 - enable write starts with buffer one
// RULE_08 - buffer one done: flags, timestamp, go two
// RULE_09 - buffer two done: same, back to one
// RULE_10 - buffer ack drops empty and its interrupt
// RULE_11 - both empty: set underrun, still switch
// RULE_12 - staging empty at bit time: bandwidth error
// RULE_13 - interrupt when flag and its enable set
// RULE_14 - flags sticky, ack clears next cycle
// RULE_15 - interrupt is source 25, level output
// RULE_16 - controller should treat it level-sensitive
// RULE_17 - timestamp counter runs on cpu clock
// RULE_18 - timestamp taken when last bit leaves
// RULE_19 - active bit: 1 buffer one, 0 two
// RULE_20 - ack bits read zero, zero writes nothing
// RULE_21 - mode codes 000, 010, 011 decoded; code tests only 011, all others go LSB-first
// RULE_22 - disable halts after current word ends
// RULE_23 - words fetched ascending from base address
`timescale 1ns/10ps
`default_nettype none
`include "sdt_consts.vh"

module sdt_out_dma
#(
   parameter TS_WIDTH = 32
)
(
   input  wire                mclk,
   input  wire                reset_n,
   input  wire [7:0]          mmio_addr,
   input  wire                mmio_wr,
   input  wire                mmio_rd,
   input  wire [31:0]         mmio_wdata,
   output reg  [31:0]         mmio_rdata,
   output reg                 mmio_rvalid,
   output reg                 mem_req,
   output reg  [31:0]         mem_addr,
   input  wire                mem_gnt,
   input  wire                mem_rvalid,
   input  wire [31:0]         mem_rdata,
   output reg                 ser_out,
   output wire                irq,
   output wire                sleepless
);

   // ***************************************************************
   // state and registers
   // ***************************************************************
   reg  [31:0]         base1_r;
   reg  [31:0]         base2_r;
   reg  [31:0]         size_r;
   reg  [31:0]         freq_r;
   reg  [TS_WIDTH-1:0] ts_cnt_r;
   reg  [TS_WIDTH-1:0] tstamp_r;
   reg                 ien_buf1_r;
   reg                 ien_buf2_r;
   reg                 ien_hbe_r;
   reg                 ien_udr_r;
   reg                 sleepless_r;
   reg                 little_r;
   reg  [2:0]          mode_r;
   reg                 enable_r;
   reg                 soft_rst_r;
   reg                 buffer_one_empty_r;
   reg                 buffer_two_empty_r;
   reg                 hbe_r;
   reg                 udr_r;
   reg                 buffer_one_active_r;
   reg                 running_r;
   reg                 fetch_buf_r;
   reg  [31:0]         fetch_off_r;
   reg                 pending_r;
   reg                 pend_last_r;
   reg                 stage_valid_r;
   reg  [31:0]         stage_word_r;
   reg                 stage_last_r;
   reg  [31:0]         shift_r;
   reg  [5:0]          bits_left_r;
   reg                 word_last_r;
   reg                 primed_r;

   wire                rst;
   wire                bit_tick;
   wire                wr_ctl;
   wire                buffer_one_ack;
   wire                buffer_two_ack;
   wire                ack_hbe;
   wire                underrun_ack;
   wire                msb_first;
   wire                fetch_last;
   wire                issue;
   wire                load_word;
   wire                starve;
   wire                buf_done;
   wire                start;

   localparam ST_IDLE = 2'b01;
   localparam ST_RUN  = 2'b10;
   reg  [1:0]          state_r;

   // ***************************************************************
   // functions
   // ***************************************************************
   // lane 0 of mem_rdata holds the byte at address a
   function [31:0] assemble;
      input [31:0] lanes;
      input        little;
      begin
         if (little)
            assemble = lanes; // RULE_05
         else
            assemble = {lanes[7:0], lanes[15:8], lanes[23:16], lanes[31:24]}; // RULE_05
      end
   endfunction

   function [31:0] buf_base;
      input        which;
      input [31:0] b1;
      input [31:0] b2;
      begin
         buf_base = which ? b2 : b1;
      end
   endfunction

   // soft reset wipes the unit like the pin reset, except the timestamp counter; receivers may see a cut word
   assign rst       = ~reset_n | soft_rst_r;
   assign wr_ctl    = mmio_wr & (mmio_addr == `SDT_OFS_CTL);
   assign buffer_one_ack  = wr_ctl & mmio_wdata[`SDT_CTL_BUFFER_ONE_ACK]; // RULE_20
   assign buffer_two_ack  = wr_ctl & mmio_wdata[`SDT_CTL_BUFFER_TWO_ACK]; // RULE_20
   assign ack_hbe   = wr_ctl & mmio_wdata[`SDT_CTL_ACK_HBE]; // RULE_20
   assign underrun_ack   = wr_ctl & mmio_wdata[`SDT_CTL_UNDERRUN_ACK]; // RULE_20
   assign msb_first = (mode_r == `SDT_MODE_MSB); // RULE_02 RULE_21
   assign sleepless = sleepless_r;

   // ***************************************************************
   // bit clock
   // ***************************************************************
   sdt_freq_synth u_synth
   (
      .mclk      (mclk),
      .rst       (rst),
      .frequency (freq_r),
      .bit_tick  (bit_tick) // RULE_03
   );

   // ***************************************************************
   // register port
   // ***************************************************************
   always @(posedge mclk)
   begin
      if (rst)
      begin
         base1_r     <= 32'h00000000;
         base2_r     <= 32'h00000000;
         size_r      <= 32'h00000000;
         freq_r      <= `SDT_FREQ_RESET;
         ien_buf1_r  <= 1'b0;
         ien_buf2_r  <= 1'b0;
         ien_hbe_r   <= 1'b0;
         ien_udr_r   <= 1'b0;
         sleepless_r <= 1'b0;
         little_r    <= 1'b0;
         mode_r      <= `SDT_MODE_IEC;
         enable_r    <= 1'b0;
         soft_rst_r  <= 1'b0;
      end
      else
      begin
         soft_rst_r <= wr_ctl & mmio_wdata[`SDT_CTL_SOFT_RST];
         if (mmio_wr)
         begin
            if (mmio_addr == `SDT_OFS_BASE1)
               base1_r <= mmio_wdata;
            else if (mmio_addr == `SDT_OFS_BASE2)
               base2_r <= mmio_wdata;
            else if (mmio_addr == `SDT_OFS_SIZE)
               size_r <= mmio_wdata;
            else if (mmio_addr == `SDT_OFS_FREQ)
               freq_r <= mmio_wdata;
            else if (mmio_addr == `SDT_OFS_CTL)
            begin
               ien_buf1_r  <= mmio_wdata[`SDT_CTL_IEN_BUF1];
               ien_buf2_r  <= mmio_wdata[`SDT_CTL_IEN_BUF2];
               ien_hbe_r   <= mmio_wdata[`SDT_CTL_IEN_HBE];
               ien_udr_r   <= mmio_wdata[`SDT_CTL_IEN_UDR];
               sleepless_r <= mmio_wdata[`SDT_CTL_SLEEPLESS];
               little_r    <= mmio_wdata[`SDT_CTL_LITTLE];
               mode_r      <= mmio_wdata[`SDT_CTL_MODE_HI:`SDT_CTL_MODE_LO]; // RULE_21
               enable_r    <= mmio_wdata[`SDT_CTL_ENABLE];
            end
         end
      end
   end

   always @(posedge mclk)
   begin
      if (rst)
      begin
         mmio_rdata  <= 32'h00000000;
         mmio_rvalid <= 1'b0;
      end
      else
      begin
         mmio_rvalid <= mmio_rd;
         mmio_rdata  <= 32'h00000000;
         if (mmio_rd)
         begin
            if (mmio_addr == `SDT_OFS_BASE1)
               mmio_rdata <= base1_r;
            else if (mmio_addr == `SDT_OFS_BASE2)
               mmio_rdata <= base2_r;
            else if (mmio_addr == `SDT_OFS_SIZE)
               mmio_rdata <= size_r;
            else if (mmio_addr == `SDT_OFS_FREQ)
               mmio_rdata <= freq_r;
            else if (mmio_addr == `SDT_OFS_TSTAMP)
               mmio_rdata <= tstamp_r;
            else if (mmio_addr == `SDT_OFS_CTL)
               mmio_rdata <= {18'h00000, enable_r, mode_r, little_r, sleepless_r,
                              ien_udr_r, ien_hbe_r, ien_buf2_r, ien_buf1_r,
                              4'h0}; // RULE_20
            else if (mmio_addr == `SDT_OFS_STATUS)
               mmio_rdata <= {27'h0000000, buffer_one_active_r, udr_r, hbe_r,
                              buffer_two_empty_r, buffer_one_empty_r}; // RULE_19
         end
      end
   end

   // ***************************************************************
   // transfer control
   // ***************************************************************
   assign start = (state_r == ST_IDLE) & enable_r & (bits_left_r == 6'h00); // RULE_07

   always @(posedge mclk)
   begin
      if (rst)
         state_r <= ST_IDLE;
      else
      begin
         case (state_r)
            ST_IDLE:
               if (start)
                  state_r <= ST_RUN;
            ST_RUN:
               if (~enable_r)
                  state_r <= ST_IDLE; // RULE_22
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   always @*
   begin
      running_r = (state_r == ST_RUN);
   end

   // ***************************************************************
   // memory fetch
   // ***************************************************************
   // a single read, issued only once the staging word is empty, keeps the bus load light
   assign fetch_last = (fetch_off_r + `SDT_WORD_BYTES >= size_r); // RULE_23
   assign issue      = running_r & enable_r & ~pending_r & ~mem_req & ~stage_valid_r;

   always @(posedge mclk)
   begin
      if (rst)
      begin
         mem_req       <= 1'b0;
         mem_addr      <= 32'h00000000;
         pending_r     <= 1'b0;
         pend_last_r   <= 1'b0;
         fetch_buf_r   <= 1'b0;
         fetch_off_r   <= 32'h00000000;
         stage_valid_r <= 1'b0;
         stage_word_r  <= 32'h00000000;
         stage_last_r  <= 1'b0;
      end
      else
      begin
         if (start)
         begin
            fetch_buf_r   <= 1'b0; // RULE_07
            fetch_off_r   <= 32'h00000000;
            stage_valid_r <= 1'b0;
         end
         else if (issue)
         begin
            mem_req     <= 1'b1;
            mem_addr    <= buf_base(fetch_buf_r, base1_r, base2_r) + fetch_off_r; // RULE_23
            pend_last_r <= fetch_last;
            if (fetch_last)
            begin
               // refill state is not checked: stale buffers are sent anyway
               fetch_buf_r <= ~fetch_buf_r; // RULE_11
               fetch_off_r <= 32'h00000000;
            end
            else
               fetch_off_r <= fetch_off_r + `SDT_WORD_BYTES;
         end
         if (mem_req & mem_gnt)
         begin
            mem_req   <= 1'b0;
            pending_r <= 1'b1;
         end
         if (pending_r & mem_rvalid)
         begin
            pending_r     <= 1'b0;
            stage_valid_r <= 1'b1;
            stage_word_r  <= assemble(mem_rdata, little_r); // RULE_04
            stage_last_r  <= pend_last_r;
         end
         else if (load_word)
            stage_valid_r <= 1'b0;
      end
   end

   // ***************************************************************
   // serializer
   // ***************************************************************
   assign load_word = bit_tick & (bits_left_r == 6'h00) & running_r & enable_r & stage_valid_r;
   assign starve    = bit_tick & (bits_left_r == 6'h00) & running_r & enable_r & ~stage_valid_r
                      & primed_r;
   assign buf_done  = bit_tick & (bits_left_r == 6'h01) & word_last_r; // RULE_18

   // no bandwidth error before the first word of a run has been staged
   always @(posedge mclk)
   begin
      if (rst | start)
         primed_r <= 1'b0;
      else if (load_word)
         primed_r <= 1'b1; // RULE_12
   end

   always @(posedge mclk)
   begin
      if (rst)
      begin
         shift_r     <= 32'h00000000;
         bits_left_r <= 6'h00;
         word_last_r <= 1'b0;
         ser_out     <= 1'b0;
      end
      else if (load_word)
      begin
         // every bit goes out untouched in all modes; no line coding here
         ser_out     <= msb_first ? stage_word_r[31] : stage_word_r[0]; // RULE_01 RULE_02
         shift_r     <= msb_first ? {stage_word_r[30:0], 1'b0}
                                  : {1'b0, stage_word_r[31:1]};
         bits_left_r <= `SDT_WORD_BITS - 6'h01; // RULE_01
         word_last_r <= stage_last_r;
      end
      else if (bit_tick & (bits_left_r != 6'h00))
      begin
         ser_out     <= msb_first ? shift_r[31] : shift_r[0]; // RULE_03
         shift_r     <= msb_first ? {shift_r[30:0], 1'b0} : {1'b0, shift_r[31:1]};
         bits_left_r <= bits_left_r - 6'h01;
      end
   end

   // ***************************************************************
   // status flags and timestamp
   // ***************************************************************
   always @(posedge mclk)
   begin
      if (~reset_n)
         ts_cnt_r <= {TS_WIDTH{1'b0}}; // RULE_17
      else
         ts_cnt_r <= ts_cnt_r + {{(TS_WIDTH-1){1'b0}}, 1'b1}; // RULE_17
   end

   always @(posedge mclk)
   begin
      if (rst)
      begin
         buffer_one_empty_r  <= 1'b0;
         buffer_two_empty_r  <= 1'b0;
         hbe_r         <= 1'b0;
         udr_r         <= 1'b0;
         buffer_one_active_r <= 1'b0;
         tstamp_r      <= {TS_WIDTH{1'b0}};
      end
      else
      begin
         if (start)
            buffer_one_active_r <= 1'b1; // RULE_19
         if (buf_done)
         begin
            // ser_out changes on this edge, so the stamp is this edge's count
            tstamp_r      <= ts_cnt_r; // RULE_18
            buffer_one_active_r <= ~buffer_one_active_r; // RULE_08 RULE_09
         end
         // hardware set wins over a same-cycle acknowledge
         buffer_one_empty_r <= (buf_done & buffer_one_active_r) | (buffer_one_empty_r & ~buffer_one_ack); // RULE_08 RULE_10 RULE_14
         buffer_two_empty_r <= (buf_done & ~buffer_one_active_r) | (buffer_two_empty_r & ~buffer_two_ack); // RULE_09 RULE_10 RULE_14
         hbe_r        <= starve | (hbe_r & ~ack_hbe); // RULE_12 RULE_14
         udr_r        <= (buf_done & (buffer_one_active_r ? buffer_two_empty_r : buffer_one_empty_r))
                         | (udr_r & ~underrun_ack); // RULE_11 RULE_14
      end
   end

   // level output for interrupt source 25; the controller should run it level-sensitive
   assign irq = (buffer_one_empty_r & ien_buf1_r) | (buffer_two_empty_r & ien_buf2_r)
              | (hbe_r & ien_hbe_r) | (udr_r & ien_udr_r); // RULE_13 RULE_15 RULE_16

endmodule // sdt_out_dma

`default_nettype wire

// [inc/sdt_consts.vh]
`ifndef SDT_CONSTS_VH
`define SDT_CONSTS_VH

// register offsets (byte addresses on the register port)
`define SDT_OFS_BASE1      8'h00
`define SDT_OFS_BASE2      8'h04
`define SDT_OFS_SIZE       8'h08
`define SDT_OFS_CTL        8'h0c
`define SDT_OFS_STATUS     8'h10
`define SDT_OFS_TSTAMP     8'h14
`define SDT_OFS_FREQ       8'h18

// transmit_control fields
`define SDT_CTL_BUFFER_ONE_ACK   0
`define SDT_CTL_BUFFER_TWO_ACK   1
`define SDT_CTL_ACK_HBE    2
`define SDT_CTL_UNDERRUN_ACK    3
`define SDT_CTL_IEN_BUF1   4
`define SDT_CTL_IEN_BUF2   5
`define SDT_CTL_IEN_HBE    6
`define SDT_CTL_IEN_UDR    7
`define SDT_CTL_SLEEPLESS  8
`define SDT_CTL_LITTLE     9
`define SDT_CTL_MODE_LO    10
`define SDT_CTL_MODE_HI    12
`define SDT_CTL_ENABLE     13
`define SDT_CTL_SOFT_RST   31

// transmit_status fields
`define SDT_ST_BUFFER_ONE_EMPTY  0
`define SDT_ST_BUFFER_TWO_EMPTY  1
`define SDT_ST_HBE         2
`define SDT_ST_UNDERRUN    3
`define SDT_ST_BUFFER_ONE_ACTIVE 4

// transmission modes
`define SDT_MODE_IEC       3'h0
`define SDT_MODE_LSB       3'h2
`define SDT_MODE_MSB       3'h3

// reset value, synthesizer and word constants
`define SDT_FREQ_RESET     32'h80000000
`define SDT_FREQ_OFFSET    32'h80000000
`define SDT_SYNTH_MULT     36'h000000009
`define SDT_WORD_BITS      6'h20
`define SDT_WORD_BYTES     32'h00000004

`endif

// [core/sdt_freq_synth.v]
`timescale 1ns/10ps
`default_nettype none
`include "sdt_consts.vh"

// phase accumulator: one tick per synthesizer clock, rate = (freq - 2^31) * 9 * f_mclk / 2^32
module sdt_freq_synth
(
   input  wire        mclk,
   input  wire        rst,
   input  wire [31:0] frequency,
   output reg         bit_tick
);

   reg  [35:0] acc_r;
   wire [35:0] step;
   wire [32:0] sum;

   // below 2^31 the synthesizer stands still rather than wrapping
   assign step = frequency[31] ? ({4'h0, frequency - `SDT_FREQ_OFFSET} * `SDT_SYNTH_MULT)
                               : 36'h000000000;
   assign sum  = {1'b0, acc_r[31:0]} + {1'b0, step[31:0]} + {29'h00000000, acc_r[35:32]};

   always @(posedge mclk)
   begin
      if (rst)
      begin
         acc_r    <= 36'h000000000;
         bit_tick <= 1'b0;
      end
      else
      begin
         acc_r    <= {3'h0, sum[32], sum[31:0]} + {step[35:32], 32'h00000000};
         bit_tick <= sum[32] | (step[35:32] != 4'h0) | (acc_r[35:33] != 3'h0);
      end
   end

endmodule // sdt_freq_synth

`default_nettype wire

// [sim/sdt_props_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// ********************
// port checks
// ********************
module sdt_props
(
   input wire        mclk,
   input wire        reset_n,
   input wire [7:0]  mmio_addr,
   input wire        mmio_wr,
   input wire        mmio_rd,
   input wire [31:0] mmio_wdata,
   input wire [31:0] mmio_rdata,
   input wire        mmio_rvalid,
   input wire        mem_req,
   input wire [31:0] mem_addr,
   input wire        mem_gnt,
   input wire        ser_out,
   input wire        irq,
   input wire        sleepless
);
   wire ctl_wr = mmio_wr && mmio_addr == 8'h0c;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   ack_zero_a:
      assert property (mmio_rd && mmio_addr == 8'h0c |=> mmio_rdata[3:0] == 4'h0)
         else $error("ack bits read back set");
   irq_mask_a:
      assert property (ctl_wr && mmio_wdata[7:4] == 4'h0 |=> !irq)
         else $error("irq with all enables off");
   req_hold_a:
      assert property (mem_req && !mem_gnt |=> mem_req && $stable(mem_addr))
         else $error("fetch request moved before grant");
   word_align_a:
      assert property (mem_req |-> mem_addr[1:0] == 2'b00)
         else $error("fetch address not word aligned");
   req_drop_a:
      assert property (mem_req && mem_gnt |=> !mem_req)
         else $error("second fetch while one outstanding");
   rd_answer_a:
      assert property (mmio_rd |=> mmio_rvalid)
         else $error("register read not answered");
   rd_only_a:
      assert property (mmio_rvalid |-> $past(mmio_rd))
         else $error("read answer without request");
   unmapped_a:
      assert property (mmio_rd && mmio_addr > 8'h18 |=> mmio_rdata == 32'h0)
         else $error("unmapped read not zero");
   quiet_reset_a:
      assert property ($rose(reset_n) |-> !irq && !mem_req && !ser_out && !mmio_rvalid)
         else $error("outputs active after reset");
   keep_awake_a:
      assert property (ctl_wr |=> sleepless == $past(mmio_wdata[8]))
         else $error("sleepless bit not copied");

   cover property (irq);
   cover property (mem_req && mem_gnt);
   cover property ($rose(ser_out));
endmodule // sdt_props
`default_nettype wire

// [sim/sdt_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ********************
// memory side: slow stretches an answer past one word time
// ********************
module sdt_mem_model
(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   output var  logic        mem_gnt,
   output var  logic        mem_rvalid,
   output var  logic [31:0] mem_rdata
);
   logic [31:0] addr_r;
   logic [9:0]  wait_r;
   logic        busy_r;

   always @(posedge mclk)
   begin
      mem_gnt    <= 1'b0;
      mem_rvalid <= 1'b0;
      // data lines toggle when idle so stale data never looks valid
      mem_rdata  <= ~mem_rdata;
      wait_r     <= wait_r - 10'h001;
      if (!reset_n)
      begin
         busy_r    <= 1'b0;
         mem_rdata <= 32'h0;
      end
      else if (busy_r && wait_r == 10'h000)
      begin
         busy_r     <= 1'b0;
         mem_rvalid <= 1'b1;
         mem_rdata  <= {addr_r[7:0] + 8'h03, addr_r[7:0] + 8'h02, addr_r[7:0] + 8'h01,
                        addr_r[7:0]} ^ 32'h81818181;
      end
      else if (!busy_r && mem_req && mem_gnt)
      begin
         busy_r <= 1'b1;
         addr_r <= mem_addr;
         wait_r <= slow ? 10'h190 : 10'h002;
      end
      else if (!busy_r && mem_req)
         mem_gnt <= 1'b1;
   end
endmodule // sdt_mem_model
`default_nettype wire

// [sim/tb_spdif_out_dma_transparent.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_spdif_out_dma_transparent;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  mmio_addr = 8'h00;
   logic        mmio_wr = 1'b0;
   logic        mmio_rd = 1'b0;
   logic [31:0] mmio_wdata = 32'h0;
   logic        slow = 1'b0;
   logic        rx_on = 1'b0;
   logic [31:0] mmio_rdata, mem_addr, mem_rdata, rx_w, v, t1;
   logic        mmio_rvalid, mem_req, mem_gnt, mem_rvalid, ser_out, irq, sleepless;
   logic [31:0] rxq[$];
   integer      bad_count = 0;
   integer      num_checks = 0;
   integer      k, n;

   sdt_out_dma dut (.mclk(mclk), .reset_n(reset_n), .mmio_addr(mmio_addr),
      .mmio_wr(mmio_wr), .mmio_rd(mmio_rd), .mmio_wdata(mmio_wdata),
      .mmio_rdata(mmio_rdata), .mmio_rvalid(mmio_rvalid), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .ser_out(ser_out), .irq(irq), .sleepless(sleepless));
   sdt_mem_model mem (.mclk(mclk), .reset_n(reset_n), .slow(slow), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata));

   initial forever #5 mclk = ~mclk;

   // ********************
   // bench tasks
   // ********************
   task chk(input [31:0] got, input [31:0] exp);
   begin
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   task complete_run;
   begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask

   task wr(input [7:0] a, input [31:0] d);
   begin
      @(negedge mclk);
      mmio_addr = a;
      mmio_wdata = d;
      mmio_wr = 1'b1;
      @(negedge mclk);
      mmio_wr = 1'b0;
   end
   endtask

   task rd(input [7:0] a, output [31:0] d);
   begin
      @(negedge mclk);
      mmio_addr = a;
      mmio_rd = 1'b1;
      @(negedge mclk);
      mmio_rd = 1'b0;
      d = mmio_rdata;
   end
   endtask

   task prepare;
   begin
      reset_n = 1'b0;
      repeat (16) @(negedge mclk);
      reset_n = 1'b1;
      rxq.delete();
      // one bit every 8 cycles keeps the receiver's sampling point fixed
      wr(8'h18, 32'h838e38e4);
      wr(8'h00, 32'h00000100);
      wr(8'h04, 32'h00000140);
      wr(8'h08, 32'h00000040);
   end
   endtask

   task wait_words(input integer cnt);
      integer t;
   begin
      for (t = 0; t < 20000 && rxq.size() < cnt; t++)
         @(negedge mclk);
   end
   endtask

   function [31:0] expw(input integer i, input lit, input [2:0] md);
      logic [7:0]  a;
      logic [31:0] w;
      integer      b;
   begin
      a = {1'b0, i[4], i[3:0], 2'b00};
      w = {a + 8'h03, a + 8'h02, a + 8'h01, a} ^ 32'h81818181;
      if (!lit)
         w = {w[7:0], w[15:8], w[23:16], w[31:24]};
      expw = w;
      if (md == 3'h3)
         for (b = 0; b < 32; b++)
            expw[b] = w[31 - b];
   end
   endfunction

   // receiver: starts on the first high bit, then samples mid-bit
   initial forever
   begin
      @(negedge mclk);
      if (rx_on && ser_out === 1'b1)
      begin
         repeat (3) @(negedge mclk);
         while (rx_on)
         begin
            for (k = 0; k < 32; k++)
            begin
               rx_w[k] = ser_out;
               repeat (8) @(negedge mclk);
            end
            rxq.push_back(rx_w);
         end
      end
   end

   task run(input lit, input [2:0] md);
      logic [31:0] cfg;
   begin
      prepare;
      cfg = 32'h000020f0 | {19'h0, md, 10'h0} | {22'h0, lit, 9'h0} | {23'h0, ~lit, 8'h0};
      rx_on = 1'b1;
      wr(8'h0c, cfg);
      wait_words(8);
      rd(8'h10, v);
      chk(v, 32'h00000010);
      rd(8'h40, v);
      chk(v, 32'h0);
      wait_words(16);
      rd(8'h10, v);
      chk(v, 32'h00000001);
      chk({31'h0, irq}, 32'h1);
      rd(8'h14, t1);
      wr(8'h0c, cfg | 32'h1);
      repeat (2) @(negedge mclk);
      rd(8'h10, v);
      chk(v, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wait_words(32);
      rd(8'h10, v);
      chk(v, 32'h00000012);
      rd(8'h14, v);
      chk(v - t1, 32'd4096);
      wait_words(48);
      rd(8'h10, v);
      chk(v, 32'h0000000b);
      rd(8'h0c, v);
      chk(v, cfg);
      chk({31'h0, sleepless}, {31'h0, ~lit});
      wr(8'h0c, cfg & ~32'hf0);
      chk({31'h0, irq}, 32'h0);
      rd(8'h10, v);
      chk(v, 32'h0000000b);
      wr(8'h0c, (cfg & ~32'hf0) | 32'hf);
      repeat (2) @(negedge mclk);
      rd(8'h10, v);
      chk(v, 32'h0);
      wait_words(49);
      wr(8'h0c, cfg & ~32'h20f0);
      wait_words(50);
      rx_on = 1'b0;
      for (n = 0; n < 50; n++)
         chk(rxq[n], expw(n, lit, md));
      v = {31'h0, ser_out};
      n = 0;
      repeat (300)
      begin
         @(negedge mclk);
         if ({31'h0, ser_out} !== v)
            n++;
      end
      chk(n, 0);
      $display("test mode %0h little %0d done", md, lit);
   end
   endtask

   initial
   begin
      repeat (60000) @(posedge mclk);
      bad_count++;
      complete_run;
   end

   initial
   begin
      run(1'b1, 3'h2);
      run(1'b0, 3'h3);
      run(1'b1, 3'h0);
      prepare;
      slow = 1'b1;
      wr(8'h0c, 32'h00002840);
      repeat (2000) @(negedge mclk);
      rd(8'h10, v);
      chk(v & 32'h4, 32'h4);
      chk({31'h0, irq}, 32'h1);
      slow = 1'b0;
      wr(8'h0c, 32'h00000000);
      wr(8'h0c, 32'h80000000);
      repeat (2) @(negedge mclk);
      rd(8'h10, v);
      chk(v, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("test bandwidth error done");
      complete_run;
   end
endmodule // tb_spdif_out_dma_transparent

bind sdt_out_dma sdt_props u_props (.mclk(mclk), .reset_n(reset_n),
   .mmio_addr(mmio_addr), .mmio_wr(mmio_wr), .mmio_rd(mmio_rd),
   .mmio_wdata(mmio_wdata), .mmio_rdata(mmio_rdata), .mmio_rvalid(mmio_rvalid),
   .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt),
   .ser_out(ser_out), .irq(irq), .sleepless(sleepless));
`default_nettype wire
